//--- core/fault_injection_countdown.sv
// Notes on behaviour
// - a recorded fake error raises fault, recovery and in-band signals chosen by its type.
// - injection only fakes detection; access data passes through untouched.
// - only types both injector and node support are injected; others inject nothing.
// - the injector supports every type the node supports.
// - the record feature view reports a nonzero support field, zero when absent.
// - injection capabilities are readable from the injection feature register.
// - injection is off while the detect enable is writable and zero.
// - in a memory-mapped group injection needs a group revision of at least one.
// - the narrow execution state cannot reach injection registers but still sees the support field.
// - writing one to the countdown enable with a nonzero value loads the counter.
// - a zero countdown value written with the enable does not load the counter; a running count keeps decrementing.
// - an enabled nonzero counter decrements each clock and enters pending at zero.
// - in pending the next access fakes the configured error and leaves pending.
// - a recorded fake error sets valid and the type flags from the control register.
// - injection registers exist only in the first record of the node.
`timescale 1ns/1ps
`default_nettype none
module fault_injection_countdown (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ctl_wr_in,
	input wire logic [fic_pkg::CTL_W-1:0] ctl_wdata_in,
	input wire logic cdn_wr_in,
	input wire logic [fic_pkg::CDN_W-1:0] cdn_wdata_in,
	input wire logic [fic_pkg::REC_IDX_W-1:0] record_select_in,
	input wire logic narrow_state_in,
	input wire logic error_detect_enable_in,
	input wire logic ed_writable_in,
	input wire logic mmio_group_in,
	input wire logic [fic_pkg::REV_W-1:0] group_arch_revision_in,
	input wire logic report_log_enable_in,
	input wire logic fh_irq_en_in,
	input wire logic fh_ce_irq_en_in,
	input wire logic er_ue_irq_en_in,
	input wire logic er_de_irq_en_in,
	input wire logic inband_en_in,
	input wire logic status_clear_in,
	input wire logic access_in,
	input wire logic [fic_pkg::DATA_W-1:0] access_data_in,
	output logic access_valid_out,
	output logic [fic_pkg::DATA_W-1:0] access_data_out,
	output logic [fic_pkg::CTL_W-1:0] inject_control_reg_out,
	output logic [fic_pkg::CDN_W-1:0] inject_countdown_reg_out,
	output logic [fic_pkg::FEAT_W-1:0] inject_feature_reg_out,
	output logic [fic_pkg::FEAT_W-1:0] record_feature_view_out,
	output logic status_valid_out,
	output logic uncorrected_flag_out,
	output logic corrected_flag_out,
	output logic deferred_flag_out,
	output logic [fic_pkg::UET_W-1:0] uncorrected_error_type_out,
	output logic fault_irq_out,
	output logic recovery_irq_out,
	output logic inband_error_out,
	output logic inject_pending_out
);
	import fic_pkg::*;

	// ==========================================================
	// reset release
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// true when the selection is exactly one type that both sides support
	function automatic logic type_ok(input logic [2:0] sel);
		logic [2:0] usable;
		usable = sel & INJ_TYPES & NODE_TYPES;
		type_ok = (sel == 3'h1 || sel == 3'h2 || sel == 3'h4) && usable != 3'h0;
	endfunction

	function automatic logic [2:0] type_sel(input logic [CTL_W-1:0] ctl);
		type_sel = {ctl[CTL_UE_POS], ctl[CTL_DE_POS], ctl[CTL_CE_POS]};
	endfunction

	// ==========================================================
	// software registers
	logic [CTL_W-1:0] ctl_ff;
	logic [CTL_W-1:0] nxt_ctl;
	logic [CDN_W-1:0] cdn_ff;
	logic [CDN_W-1:0] nxt_cdn;
	logic load_ff;
	logic nxt_load;
	logic reg_reach;

	always_comb begin
		// the narrow state and later records see no injection registers
		reg_reach = !narrow_state_in && record_select_in == FIRST_RECORD;
		nxt_ctl = ctl_ff;
		nxt_cdn = cdn_ff;
		nxt_load = 1'b0;
		if (ctl_wr_in && reg_reach) begin
			nxt_ctl = ctl_wdata_in;
			nxt_load = ctl_wdata_in[CTL_COUNTDOWN_ENABLE_POS];
		end
		if (cdn_wr_in && reg_reach) begin
			nxt_cdn = cdn_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ctl_ff <= CTL_RESET;
			cdn_ff <= CDN_RESET;
			load_ff <= 1'b0;
		end else begin
			ctl_ff <= nxt_ctl;
			cdn_ff <= nxt_cdn;
			load_ff <= nxt_load;
		end
	end

	// ==========================================================
	// injection gating and counter
	logic allowed;
	logic pending;
	logic fire;
	logic [2:0] sel;

	always_comb begin
		sel = type_sel(ctl_ff);
		allowed = !(ed_writable_in && !error_detect_enable_in)
			&& (!mmio_group_in || group_arch_revision_in >= MIN_GROUP_REV);
	end

	error_gen_counter u_counter (
		.clk_in(clk_in),
		.rst_n_in(rst_sync_ff),
		.load_in(load_ff),
		.load_val_in(cdn_ff),
		.enable_in(ctl_ff[CTL_COUNTDOWN_ENABLE_POS]),
		.allowed_in(allowed),
		.access_in(access_in),
		.type_ok_in(type_ok(sel)),
		.pending_out(pending),
		.fire_out(fire)
	);

	// ==========================================================
	// error record status and signalling
	logic valid_ff;
	logic nxt_valid;
	logic ue_ff;
	logic nxt_ue;
	logic ce_ff;
	logic nxt_ce;
	logic de_ff;
	logic nxt_de;
	logic [UET_W-1:0] uet_ff;
	logic [UET_W-1:0] nxt_uet;
	logic fh_ff;
	logic nxt_fh;
	logic er_ff;
	logic nxt_er;
	logic ib_ff;
	logic nxt_ib;
	logic rec;

	always_comb begin
		rec = fire && report_log_enable_in;
		nxt_valid = valid_ff;
		nxt_ue = ue_ff;
		nxt_ce = ce_ff;
		nxt_de = de_ff;
		nxt_uet = uet_ff;
		if (status_clear_in) begin
			nxt_valid = 1'b0;
			nxt_ue = 1'b0;
			nxt_ce = 1'b0;
			nxt_de = 1'b0;
			nxt_uet = UET_RESET;
		end
		// a record landing with a clear wins over the clear
		if (rec) begin
			nxt_valid = 1'b1;
			nxt_ue = sel[2];
			nxt_de = sel[1];
			nxt_ce = sel[0];
			nxt_uet = sel[2] ? ctl_ff[CTL_UET_LSB +: UET_W] : UET_RESET;
		end
		nxt_fh = rec && ((fh_irq_en_in && (sel[2] || sel[1])) || (fh_ce_irq_en_in && sel[0]));
		nxt_er = rec && ((er_ue_irq_en_in && sel[2]) || (er_de_irq_en_in && sel[1]));
		nxt_ib = rec && inband_en_in && sel[2];
	end

	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			valid_ff <= 1'b0;
			ue_ff <= 1'b0;
			ce_ff <= 1'b0;
			de_ff <= 1'b0;
			uet_ff <= UET_RESET;
			fh_ff <= 1'b0;
			er_ff <= 1'b0;
			ib_ff <= 1'b0;
		end else begin
			valid_ff <= nxt_valid;
			ue_ff <= nxt_ue;
			ce_ff <= nxt_ce;
			de_ff <= nxt_de;
			uet_ff <= nxt_uet;
			fh_ff <= nxt_fh;
			er_ff <= nxt_er;
			ib_ff <= nxt_ib;
		end
	end

	// ==========================================================
	// read views and data path
	logic [CTL_W-1:0] rd_ctl_ff;
	logic [CTL_W-1:0] nxt_rd_ctl;
	logic [CDN_W-1:0] rd_cdn_ff;
	logic [CDN_W-1:0] nxt_rd_cdn;
	logic [FEAT_W-1:0] rd_feat_ff;
	logic [FEAT_W-1:0] nxt_rd_feat;
	logic [FEAT_W-1:0] view_ff;
	logic [FEAT_W-1:0] nxt_view;
	logic [DATA_W-1:0] data_ff;
	logic data_vld_ff;
	logic pend_ff;

	always_comb begin
		nxt_rd_ctl = reg_reach ? ctl_ff : CTL_RESET;
		nxt_rd_cdn = reg_reach ? cdn_ff : CDN_RESET;
		nxt_rd_feat = FEAT_RESET;
		if (reg_reach) begin
			nxt_rd_feat[FEAT_TYPES_LSB +: 3] = INJ_TYPES & NODE_TYPES;
			nxt_rd_feat[FEAT_CDN_POS] = 1'b1;
		end
		// the support field stays visible from every state through the view
		nxt_view = FEAT_RESET;
		nxt_view[FEAT_VIEW_INJ_LSB +: 2] = (record_select_in == FIRST_RECORD) ? INJ_SUPPORT : INJ_ABSENT;
	end

	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			rd_ctl_ff <= CTL_RESET;
			rd_cdn_ff <= CDN_RESET;
			rd_feat_ff <= FEAT_RESET;
			view_ff <= FEAT_RESET;
			data_ff <= DATA_RESET;
			data_vld_ff <= 1'b0;
			pend_ff <= 1'b0;
		end else begin
			rd_ctl_ff <= nxt_rd_ctl;
			rd_cdn_ff <= nxt_rd_cdn;
			rd_feat_ff <= nxt_rd_feat;
			view_ff <= nxt_view;
			data_ff <= access_data_in;
			data_vld_ff <= access_in;
			pend_ff <= pending;
		end
	end

	always_comb begin
		access_valid_out = data_vld_ff;
		access_data_out = data_ff;
		inject_control_reg_out = rd_ctl_ff;
		inject_countdown_reg_out = rd_cdn_ff;
		inject_feature_reg_out = rd_feat_ff;
		record_feature_view_out = view_ff;
		status_valid_out = valid_ff;
		uncorrected_flag_out = ue_ff;
		corrected_flag_out = ce_ff;
		deferred_flag_out = de_ff;
		uncorrected_error_type_out = uet_ff;
		fault_irq_out = fh_ff;
		recovery_irq_out = er_ff;
		inband_error_out = ib_ff;
		inject_pending_out = pend_ff;
	end
endmodule // fault_injection_countdown
`default_nettype wire

//--- shared/fic_pkg.sv
package fic_pkg;
	// ==========================================================
	// widths
	localparam int CTL_W = 6;
	localparam int CDN_W = 32;
	localparam int FEAT_W = 8;
	localparam int DATA_W = 32;
	localparam int REC_IDX_W = 4;
	localparam int REV_W = 4;
	localparam int UET_W = 2;
	// ==========================================================
	// control register fields
	localparam int CTL_COUNTDOWN_ENABLE_POS = 0;
	localparam int CTL_CE_POS = 1;
	localparam int CTL_DE_POS = 2;
	localparam int CTL_UE_POS = 3;
	localparam int CTL_UET_LSB = 4;
	// ==========================================================
	// feature register fields
	localparam int FEAT_TYPES_LSB = 0;
	localparam int FEAT_CDN_POS = 3;
	localparam int FEAT_VIEW_INJ_LSB = 0;
	// error type masks, order {ue, de, ce}
	localparam logic [2:0] NODE_TYPES = 3'h7;
	localparam logic [2:0] INJ_TYPES = 3'h7;
	localparam logic [1:0] INJ_SUPPORT = 2'h1;
	localparam logic [1:0] INJ_ABSENT = 2'h0;
	localparam logic [REV_W-1:0] MIN_GROUP_REV = 4'h1;
	localparam logic [REC_IDX_W-1:0] FIRST_RECORD = 4'h0;
	// ==========================================================
	// reset values
	localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
	localparam logic [CDN_W-1:0] CDN_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
	localparam logic [UET_W-1:0] UET_RESET = 2'h0;
	localparam logic [FEAT_W-1:0] FEAT_RESET = 8'h00;

	typedef enum logic [2:0] {
		CNT_IDLE = 3'b001,
		CNT_RUN = 3'b010,
		CNT_PEND = 3'b100
	} cnt_state_e;
endpackage

//--- core/error_gen_counter.sv
`timescale 1ns/1ps
`default_nettype none
module error_gen_counter (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [fic_pkg::CDN_W-1:0] load_val_in,
	input wire logic enable_in,
	input wire logic allowed_in,
	input wire logic access_in,
	input wire logic type_ok_in,
	output logic pending_out,
	output logic fire_out
);
	import fic_pkg::*;

	cnt_state_e state_ff;
	cnt_state_e nxt_state;
	logic [CDN_W-1:0] cnt_ff;
	logic [CDN_W-1:0] nxt_cnt;
	logic run_ok;

	// ==========================================================
	// countdown and pending state
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		fire_out = 1'b0;
		run_ok = enable_in && allowed_in;
		case (state_ff)
			CNT_IDLE: begin
				// a zero countdown written with the enable leaves the counter alone
				if (load_in && load_val_in != CDN_RESET) begin
					nxt_cnt = load_val_in;
					nxt_state = CNT_RUN;
				end
			end
			CNT_RUN: begin
				if (load_in && load_val_in != CDN_RESET) begin
					nxt_cnt = load_val_in;
				end else if (run_ok) begin
					nxt_cnt = cnt_ff - 32'h0000_0001;
					if (cnt_ff == 32'h0000_0001) begin
						nxt_state = CNT_PEND;
					end
				end
			end
			CNT_PEND: begin
				if (load_in && load_val_in != CDN_RESET) begin
					nxt_cnt = load_val_in;
					nxt_state = CNT_RUN;
				end else if (access_in && run_ok) begin
					// an unsupported type still leaves the pending state, but fakes nothing
					fire_out = type_ok_in;
					nxt_state = CNT_IDLE;
				end
			end
			default: begin
				nxt_state = CNT_IDLE;
			end
		endcase
		pending_out = (state_ff == CNT_PEND);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= CNT_IDLE;
			cnt_ff <= CDN_RESET;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule // error_gen_counter
`default_nettype wire

//--- verif/fault_injection_countdown_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fault_injection_countdown_asserts (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [fic_pkg::REC_IDX_W-1:0] record_select_in,
	input wire logic narrow_state_in,
	input wire logic error_detect_enable_in,
	input wire logic ed_writable_in,
	input wire logic mmio_group_in,
	input wire logic [fic_pkg::REV_W-1:0] group_arch_revision_in,
	input wire logic access_in,
	input wire logic [fic_pkg::DATA_W-1:0] access_data_in,
	input wire logic access_valid_out,
	input wire logic [fic_pkg::DATA_W-1:0] access_data_out,
	input wire logic [fic_pkg::CTL_W-1:0] inject_control_reg_out,
	input wire logic [fic_pkg::FEAT_W-1:0] inject_feature_reg_out,
	input wire logic [fic_pkg::FEAT_W-1:0] record_feature_view_out,
	input wire logic status_valid_out,
	input wire logic uncorrected_flag_out,
	input wire logic fault_irq_out,
	input wire logic recovery_irq_out,
	input wire logic inband_error_out
);
	import fic_pkg::*;
	// ==========================================================
	// outputs are held low through the internal reset sync, so wait it out
	logic [2:0] live_ff;
	logic [2:0] nxt_live;
	logic live;
	always_comb nxt_live = (live_ff == 3'h5) ? live_ff : live_ff + 3'h1;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) live_ff <= 3'h0;
		else live_ff <= nxt_live;
	end
	assign live = (live_ff == 3'h5);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in || !live);
	// ==========================================================
	// properties
	property p_data_kept;
		$past(access_in) |-> access_valid_out && access_data_out == $past(access_data_in);
	endproperty
	a_data_kept: assert property (p_data_kept) else $error("access data altered");
	property p_view;
		record_feature_view_out[1:0] == (($past(record_select_in) == FIRST_RECORD) ? INJ_SUPPORT : INJ_ABSENT);
	endproperty
	a_view: assert property (p_view) else $error("support field wrong");
	property p_gate;
		($past(narrow_state_in) || $past(record_select_in) != FIRST_RECORD)
			|-> inject_control_reg_out == '0 && inject_feature_reg_out == '0;
	endproperty
	a_gate: assert property (p_gate) else $error("gated registers visible");
	property p_feat;
		(!$past(narrow_state_in) && $past(record_select_in) == FIRST_RECORD)
			|-> inject_feature_reg_out[2:0] == INJ_TYPES && inject_feature_reg_out[FEAT_CDN_POS];
	endproperty
	a_feat: assert property (p_feat) else $error("feature register wrong");
	property p_irq;
		(fault_irq_out || recovery_irq_out || inband_error_out) |-> status_valid_out;
	endproperty
	a_irq: assert property (p_irq) else $error("signal without record");
	property p_inband;
		inband_error_out |-> uncorrected_flag_out && !$past(inband_error_out);
	endproperty
	a_inband: assert property (p_inband) else $error("in-band response wrong");
	property p_rec;
		$rose(status_valid_out) |-> $past(access_in);
	endproperty
	a_rec: assert property (p_rec) else $error("record without access");
	property p_ed;
		$past(ed_writable_in && !error_detect_enable_in) |-> !$rose(status_valid_out);
	endproperty
	a_ed: assert property (p_ed) else $error("injected while detect off");
	property p_rev;
		$past(mmio_group_in && group_arch_revision_in < MIN_GROUP_REV) |-> !$rose(status_valid_out);
	endproperty
	a_rev: assert property (p_rev) else $error("injected at low revision");
endmodule // fault_injection_countdown_asserts
bind fault_injection_countdown fault_injection_countdown_asserts u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.record_select_in(record_select_in), .narrow_state_in(narrow_state_in),
	.error_detect_enable_in(error_detect_enable_in), .ed_writable_in(ed_writable_in),
	.mmio_group_in(mmio_group_in), .group_arch_revision_in(group_arch_revision_in), .access_in(access_in),
	.access_data_in(access_data_in), .access_valid_out(access_valid_out), .access_data_out(access_data_out),
	.inject_control_reg_out(inject_control_reg_out), .inject_feature_reg_out(inject_feature_reg_out),
	.record_feature_view_out(record_feature_view_out), .status_valid_out(status_valid_out),
	.uncorrected_flag_out(uncorrected_flag_out), .fault_irq_out(fault_irq_out),
	.recovery_irq_out(recovery_irq_out), .inband_error_out(inband_error_out));
`default_nettype wire

//--- verif/fault_injection_countdown_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_injection_countdown_tb;
	import fic_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ctl_wr_in = 1'b0;
	logic cdn_wr_in = 1'b0;
	logic [CTL_W-1:0] ctl_wdata_in = '0;
	logic [CDN_W-1:0] cdn_wdata_in = '0;
	logic [REC_IDX_W-1:0] record_select_in = '0;
	logic narrow_state_in = 1'b0;
	logic error_detect_enable_in = 1'b1;
	logic ed_writable_in = 1'b0;
	logic mmio_group_in = 1'b0;
	logic [REV_W-1:0] group_arch_revision_in = '0;
	logic en_all = 1'b1;
	logic status_clear_in = 1'b0;
	logic access_in = 1'b0;
	logic [DATA_W-1:0] access_data_in = 32'h5a5a_0000;
	logic access_valid_out, status_valid_out, uncorrected_flag_out, corrected_flag_out, deferred_flag_out;
	logic fault_irq_out, recovery_irq_out, inband_error_out, inject_pending_out;
	logic [DATA_W-1:0] access_data_out;
	logic [CTL_W-1:0] inject_control_reg_out;
	logic [CDN_W-1:0] inject_countdown_reg_out;
	logic [FEAT_W-1:0] inject_feature_reg_out, record_feature_view_out;
	logic [UET_W-1:0] uncorrected_error_type_out;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	fault_injection_countdown uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ctl_wr_in(ctl_wr_in),
		.ctl_wdata_in(ctl_wdata_in), .cdn_wr_in(cdn_wr_in), .cdn_wdata_in(cdn_wdata_in),
		.record_select_in(record_select_in), .narrow_state_in(narrow_state_in),
		.error_detect_enable_in(error_detect_enable_in), .ed_writable_in(ed_writable_in),
		.mmio_group_in(mmio_group_in), .group_arch_revision_in(group_arch_revision_in),
		.report_log_enable_in(en_all), .fh_irq_en_in(en_all), .fh_ce_irq_en_in(en_all),
		.er_ue_irq_en_in(en_all), .er_de_irq_en_in(en_all), .inband_en_in(en_all),
		.status_clear_in(status_clear_in), .access_in(access_in), .access_data_in(access_data_in),
		.access_valid_out(access_valid_out), .access_data_out(access_data_out),
		.inject_control_reg_out(inject_control_reg_out), .inject_countdown_reg_out(inject_countdown_reg_out),
		.inject_feature_reg_out(inject_feature_reg_out), .record_feature_view_out(record_feature_view_out),
		.status_valid_out(status_valid_out), .uncorrected_flag_out(uncorrected_flag_out),
		.corrected_flag_out(corrected_flag_out), .deferred_flag_out(deferred_flag_out),
		.uncorrected_error_type_out(uncorrected_error_type_out), .fault_irq_out(fault_irq_out),
		.recovery_irq_out(recovery_irq_out), .inband_error_out(inband_error_out),
		.inject_pending_out(inject_pending_out));
	// ==========================================================
	// clock and hang guard
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			conclude();
		end
	end
	// ==========================================================
	// shared tasks, all entered and left at a falling edge
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (!ok) begin
			miscompares++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic wr_cdn(input logic [CDN_W-1:0] v);
		cdn_wr_in = 1'b1;
		cdn_wdata_in = v;
		@(negedge clk_in);
		cdn_wr_in = 1'b0;
	endtask
	task automatic wr_ctl(input logic [CTL_W-1:0] v);
		ctl_wr_in = 1'b1;
		ctl_wdata_in = v;
		@(negedge clk_in);
		ctl_wr_in = 1'b0;
	endtask
	task automatic wait_pend(output int n);
		n = 0;
		while (inject_pending_out !== 1'b1 && n < 100) begin
			@(negedge clk_in);
			n++;
		end
	endtask
	task automatic poke();
		access_in = 1'b1;
		access_data_in = ~access_data_in;
		@(negedge clk_in);
		access_in = 1'b0;
	endtask
	task automatic clear();
		status_clear_in = 1'b1;
		@(negedge clk_in);
		status_clear_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk(status_valid_out === 1'b0, "status not cleared");
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		logic [FEAT_W-1:0] exp_feat;
		exp_feat = '0;
		exp_feat[FEAT_TYPES_LSB +: 3] = INJ_TYPES;
		exp_feat[FEAT_CDN_POS] = 1'b1;
		wr_ctl(6'h2a);
		wr_cdn(32'h1234_5678);
		@(negedge clk_in);
		chk(inject_control_reg_out === 6'h2a && inject_countdown_reg_out === 32'h1234_5678, "readback");
		chk(inject_feature_reg_out === exp_feat && record_feature_view_out[1:0] === INJ_SUPPORT, "feat");
		record_select_in = 4'h1;
		wr_ctl(6'h00);
		@(negedge clk_in);
		chk(inject_control_reg_out === 6'h00 && record_feature_view_out[1:0] === INJ_ABSENT, "rec1");
		record_select_in = FIRST_RECORD;
		narrow_state_in = 1'b1;
		wr_ctl(6'h00);
		@(negedge clk_in);
		chk(inject_feature_reg_out === 8'h00 && record_feature_view_out[1:0] === INJ_SUPPORT, "narrow");
		narrow_state_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk(inject_control_reg_out === 6'h2a, "refused write landed");
		$display("test regs done");
	endtask
	task automatic t_inject(input logic [CTL_W-1:0] c, input int n);
		int k;
		logic [DATA_W-1:0] d;
		wr_cdn(n);
		wr_ctl(c);
		wait_pend(k);
		chk(k == n + 2, "countdown length");
		poke();
		d = access_data_in;
		chk(access_valid_out === 1'b1 && access_data_out === d, "data altered");
		chk(status_valid_out === 1'b1 && corrected_flag_out === c[CTL_CE_POS], "ce");
		chk(deferred_flag_out === c[CTL_DE_POS] && uncorrected_flag_out === c[CTL_UE_POS], "de ue");
		chk(uncorrected_error_type_out === (c[CTL_UE_POS] ? c[5:4] : UET_RESET), "uet");
		chk(fault_irq_out === 1'b1 && recovery_irq_out === (c[CTL_UE_POS] | c[CTL_DE_POS]), "irq");
		chk(inband_error_out === c[CTL_UE_POS], "in-band");
		@(negedge clk_in);
		chk(fault_irq_out === 1'b0 && inject_pending_out === 1'b0, "pending kept");
		clear();
		$display("test inject %0h done", c);
	endtask
	task automatic t_invalid();
		int k;
		wr_cdn(2);
		wr_ctl(6'h0b);
		wait_pend(k);
		poke();
		chk(status_valid_out === 1'b0 && fault_irq_out === 1'b0, "bad type injected");
		@(negedge clk_in);
		chk(inject_pending_out === 1'b0, "pending kept");
		$display("test invalid done");
	endtask
	task automatic t_gate();
		int k;
		ed_writable_in = 1'b1;
		error_detect_enable_in = 1'b0;
		wr_cdn(3);
		wr_ctl(6'h03);
		repeat (20) @(negedge clk_in);
		poke();
		chk(inject_pending_out === 1'b0 && status_valid_out === 1'b0, "ran while detect off");
		error_detect_enable_in = 1'b1;
		wait_pend(k);
		mmio_group_in = 1'b1;
		poke();
		@(negedge clk_in);
		chk(status_valid_out === 1'b0 && inject_pending_out === 1'b1, "low revision");
		group_arch_revision_in = MIN_GROUP_REV;
		poke();
		chk(status_valid_out === 1'b1, "revision one refused");
		clear();
		$display("test gate done");
	endtask
	task automatic t_halt();
		wr_cdn(0);
		wr_ctl(6'h03);
		repeat (10) @(negedge clk_in);
		chk(inject_pending_out === 1'b0, "zero count pended");
		wr_cdn(6);
		wr_ctl(6'h03);
		repeat (3) @(negedge clk_in);
		wr_ctl(6'h02);
		repeat (20) @(negedge clk_in);
		chk(inject_pending_out === 1'b0, "ran while disabled");
		$display("test halt done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (5) @(negedge clk_in);
		t_regs();
		t_inject(6'h03, 1);
		t_inject(6'h05, 4);
		t_inject(6'h29, 7);
		t_invalid();
		t_gate();
		t_halt();
		conclude();
	end
endmodule // fault_injection_countdown_tb
`default_nettype wire
